/* adcss_pkg.sv */
package adcss_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_EXT = 6'h01;
  localparam logic [5:0] OFS_ACC = 6'h02;
  localparam logic [5:0] OFS_SEL_A = 6'h03;
  localparam logic [5:0] OFS_SEL_B = 6'h04;
  localparam logic [5:0] OFS_SEL_C = 6'h05;
  localparam logic [5:0] OFS_ADD_SEL = 6'h06;
  localparam logic [5:0] OFS_TRG_SEL = 6'h07;
  localparam logic [5:0] OFS_WIN_A_LO = 6'h08;
  localparam logic [5:0] OFS_WIN_A_HI = 6'h09;
  localparam logic [5:0] OFS_WIN_B_LO = 6'h0A;
  localparam logic [5:0] OFS_WIN_B_HI = 6'h0B;
  localparam logic [5:0] OFS_CMP_CTL = 6'h0C;
  localparam logic [5:0] OFS_WIN_A_SEL = 6'h0D;
  localparam logic [5:0] OFS_WIN_B_SEL = 6'h0E;
  localparam logic [5:0] OFS_STATUS = 6'h0F;
  localparam logic [5:0] OFS_SAMP = 6'h10;
  localparam logic [5:0] OFS_RESULT = 6'h20;
  localparam logic [5:0] OFS_DUP = 6'h30;
  localparam logic [5:0] OFS_DUP_SYNC = 6'h31;
  localparam logic [5:0] OFS_DUP_PIN = 6'h32;
  // converter_control bits
  localparam int CTRL_START = 15;
  localparam int CTRL_MODE_HI = 14;
  localparam int CTRL_MODE_LO = 13;
  localparam int CTRL_IRQ_EN = 12;
  localparam int CTRL_HW_TRIGGER_ENABLE = 9;
  localparam int CTRL_TRIGGER_CLASS_SELECT = 8;
  // extended control bits
  localparam int EXT_DBL_CH_HI = 4;
  localparam int EXT_DOUBLE_TRIGGER_ENABLE = 5;
  localparam int EXT_GB_IRQ = 6;
  localparam int EXT_GC_IRQ = 7;
  localparam int EXT_PRIO = 8;
  localparam int EXT_RESCAN = 9;
  localparam int EXT_RESCAN_UNCONV = 10;
  localparam int EXT_RES_LO = 11;
  localparam int EXT_RES_HI = 12;
  localparam int EXT_DBL_TYPED = 13;
  // accumulate config bits
  localparam int ACC_AVG = 3;
  localparam int ACC_AUTOCLR = 4;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_GROUP = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8 = 2'h2;
  localparam logic [2:0] ADD_X16 = 3'h5;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [7:0] SAMP_RST = 8'h0B;
  localparam logic [15:0] TRG_SEL_RST = 16'hFFFF;
endpackage

/* adcss_scan_sequencer.sv */
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module adcss_scan_sequencer
  import adcss_pkg::*;
#(
  parameter int NCH = 8,
  parameter int CLK_RATIO = 1,
  parameter int NTRIG = 16
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [NTRIG-1:0] sync_trig_i,
  input wire logic ext_trigger_pin_n_i,
  output logic conv_clk_en_o,
  output logic conv_start_o,
  output logic [3:0] conv_ch_o,
  output logic [1:0] conv_res_o,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_data_i,
  output logic scan_end_request_o,
  output logic group_b_end_request_o,
  output logic group_c_end_request_o,
  output logic window_a_compare_request_o,
  output logic window_b_compare_request_o,
  output logic event_link_o,
  output logic busy_o
);

  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_CONV} adcss_state_type;

  localparam logic [16:0] ONE17 = 17'h0_0001;
  localparam logic [15:0] CH_VALID = 16'((ONE17 << NCH) - ONE17);
  localparam logic [2:0] DIV_LAST = 3'(CLK_RATIO - 1);

  if (NCH < 1 || NCH > 16 || NTRIG < 1 || NTRIG > 16 ||
      !(CLK_RATIO inside {1, 2, 4, 8})) begin : g_param_chk
    $error("adcss_scan_sequencer: unsupported parameter value");
  end

  function automatic logic [3:0] low_bit(input logic [15:0] m);
    low_bit = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        low_bit = 4'(i);
      end
    end
  endfunction

  function automatic logic [2:0] grp_hot(input logic [1:0] g);
    grp_hot = 3'(3'h1 << g);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [15:0] ctrl_r;
  logic [15:0] ext_r;
  logic [15:0] acc_cfg_r;
  logic [15:0] add_sel_r;
  logic [15:0] trg_sel_r;
  logic [15:0] cmp_ctrl_r;
  logic [15:0] sel_r [0:2];
  logic [15:0] win_lo_r [0:1];
  logic [15:0] win_hi_r [0:1];
  logic [15:0] win_sel_r [0:1];
  logic [7:0] samp_r [0:15];
  logic [15:0] result_r [0:15];
  logic [15:0] dup_r;
  logic [15:0] dup_t_r [0:1];
  logic [15:0] rdata_r;

  adcss_state_type state_r;
  logic [1:0] act_r;
  logic [15:0] rem_r;
  logic [3:0] ch_r;
  logic [2:0] pend_r;
  logic [2:0] use_res_r;
  logic [15:0] res_mask_r [0:2];
  logic [2:0] half_r;
  logic src_r;
  logic [7:0] smp_cnt_r;
  logic [4:0] rep_r;
  logic [15:0] acc_r;
  logic [2:0] div_r;
  logic end_a_r;
  logic end_b_r;
  logic end_c_r;
  logic evt_r;
  logic [1:0] cmp_p_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;

  logic [1:0] mode;
  logic grp_mode;
  logic dbl_mode;
  logic hw_ok;
  logic ext_fall;
  logic sw_start;
  logic sw_stop;
  logic [15:0] trig_pad;
  logic [2:0] req;
  logic [2:0] pend_all;
  logic [2:0] hmask;
  logic pre_v;
  logic [1:0] pre_g;
  logic [1:0] nxt_g;
  logic [3:0] pre_idx;
  logic [3:0] pend_idx;
  logic [15:0] nxt_mask;
  logic [15:0] gmask [0:2];
  logic [15:0] rem_left;
  logic [15:0] conv_val;
  logic [4:0] add_last;
  logic [2:0] avg_sh;
  logic [15:0] sum;
  logic st_v;
  logic [15:0] st_val;
  logic [1:0] st_dst;
  logic dbl_hit;
  logic end_fire;
  logic wr_ctrl;

  ////////////////////////////////////////////////////////////////////////
  // external pin: two stages before any logic, third for the edge
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_s3_r <= 1'b1;
    end else if (ce_i) begin
      pin_s1_r <= ext_trigger_pin_n_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      div_r <= 3'h0;
    end else if (ce_i) begin
      div_r <= (div_r == DIV_LAST) ? 3'h0 : div_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode field decode
  assign mode = ctrl_r[CTRL_MODE_HI:CTRL_MODE_LO];
  assign grp_mode = (mode == MODE_GROUP);
  assign dbl_mode = ext_r[EXT_DOUBLE_TRIGGER_ENABLE];
  assign hw_ok = ctrl_r[CTRL_HW_TRIGGER_ENABLE];
  assign ext_fall = pin_s3_r & ~pin_s2_r;
  assign wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
  assign sw_start = wr_ctrl && reg_wdata_i[CTRL_START];
  assign sw_stop = wr_ctrl && !reg_wdata_i[CTRL_START];
  assign trig_pad = 16'(sync_trig_i);
  assign conv_clk_en_o = (div_r == 3'h0);
  assign conv_start_o = ce_i && (state_r == S_SAMPLE) && conv_clk_en_o && (smp_cnt_r == 8'h00);
  assign conv_ch_o = ch_r;
  assign conv_res_o = ext_r[EXT_RES_HI:EXT_RES_LO];
  assign busy_o = (state_r != S_IDLE);

  always_comb begin
    for (int g = 0; g < 3; g++) begin
      if (grp_mode) begin
        gmask[g] = sel_r[g] & CH_VALID;
      end else if (dbl_mode) begin
        gmask[g] = 16'(16'h0001 << ext_r[3:0]) & CH_VALID;
      end else begin
        gmask[g] = sel_r[0] & CH_VALID;
      end
    end
  end

  always_comb begin
    for (int g = 0; g < 3; g++) begin
      req[g] = hw_ok && !ctrl_r[CTRL_TRIGGER_CLASS_SELECT] && trig_pad[trg_sel_r[4*g +: 4]];
    end
    req[0] = req[0] || sw_start || (hw_ok && ctrl_r[CTRL_TRIGGER_CLASS_SELECT] && ext_fall);
    req[1] = req[1] && grp_mode;
    req[2] = req[2] && grp_mode;
    // an empty group never starts, so two groups means any two of A, B and C with the third left empty
    for (int g = 0; g < 3; g++) begin
      req[g] = req[g] && (|gmask[g]) && !sw_stop;
    end
  end

  assign pend_all = pend_r | req;
  assign hmask = 3'(grp_hot(act_r) - 3'h1);
  assign pre_v = grp_mode && ext_r[EXT_PRIO] && (state_r != S_IDLE) && |(req & hmask);
  assign pre_idx = low_bit({13'h0000, req & hmask});
  assign pend_idx = low_bit({13'h0000, pend_all});
  assign pre_g = pre_idx[1:0];
  assign nxt_g = pre_v ? pre_g : pend_idx[1:0];
  assign nxt_mask = use_res_r[nxt_g] ? res_mask_r[nxt_g] : gmask[nxt_g];
  assign rem_left = rem_r & ~16'(16'h0001 << ch_r);

  always_comb begin
    case (ext_r[EXT_RES_HI:EXT_RES_LO])
      RES_10: conv_val = {6'h00, conv_data_i[11:2]};
      RES_8: conv_val = {8'h00, conv_data_i[11:4]};
      default: conv_val = {4'h0, conv_data_i};
    endcase
  end

  always_comb begin
    case (acc_cfg_r[2:0])
      ADD_X16: begin
        add_last = 5'h0F;
        avg_sh = 3'h4;
      end
      3'h1: begin
        add_last = 5'h01;
        avg_sh = 3'h1;
      end
      3'h2: begin
        add_last = 5'h02;
        avg_sh = 3'h0;
      end
      3'h3: begin
        add_last = 5'h03;
        avg_sh = 3'h2;
      end
      default: begin
        add_last = 5'h00;
        avg_sh = 3'h0;
      end
    endcase
    if (!add_sel_r[ch_r]) begin
      add_last = 5'h00;
      avg_sh = 3'h0;
    end
  end

  assign sum = acc_r + conv_val;
  assign st_val = acc_cfg_r[ACC_AVG] ? (sum >> avg_sh) : sum;
  assign st_v = ce_i && (state_r == S_CONV) && conv_done_i && (rep_r == add_last);
  assign dbl_hit = dbl_mode && (ch_r == ext_r[3:0]) && (mode != MODE_CONT);
  assign end_fire = !dbl_mode || half_r[act_r];

  always_comb begin
    if (dbl_hit && ext_r[EXT_DBL_TYPED]) begin
      st_dst = src_r ? 2'h3 : 2'h2;
    end else if (dbl_hit && half_r[act_r]) begin
      st_dst = 2'h1;
    end else begin
      st_dst = 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scan engine
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r <= S_IDLE;
      act_r <= 2'h0;
      rem_r <= REG_RST;
      ch_r <= 4'h0;
      pend_r <= 3'h0;
      use_res_r <= 3'h0;
      half_r <= 3'h0;
      src_r <= 1'b0;
      smp_cnt_r <= 8'h00;
      rep_r <= 5'h00;
      acc_r <= REG_RST;
      end_a_r <= 1'b0;
      end_b_r <= 1'b0;
      end_c_r <= 1'b0;
      evt_r <= 1'b0;
      for (int g = 0; g < 3; g++) begin
        res_mask_r[g] <= REG_RST;
      end
    end else if (ce_i) begin
      end_a_r <= 1'b0;
      end_b_r <= 1'b0;
      end_c_r <= 1'b0;
      evt_r <= 1'b0;
      pend_r <= pend_all;
      if (sw_stop) begin
        state_r <= S_IDLE;
        pend_r <= 3'h0;
        use_res_r <= 3'h0;
      end else if (pre_v || (state_r == S_IDLE && |pend_all)) begin
        if (pre_v && ext_r[EXT_RESCAN]) begin
          res_mask_r[act_r] <= ext_r[EXT_RESCAN_UNCONV] ? rem_r : gmask[act_r];
          use_res_r <= (use_res_r | grp_hot(act_r)) & ~grp_hot(nxt_g);
          pend_r <= (pend_all | grp_hot(act_r)) & ~grp_hot(nxt_g);
        end else begin
          use_res_r[nxt_g] <= 1'b0;
          pend_r <= pend_all & ~grp_hot(nxt_g);
        end
        act_r <= nxt_g;
        rem_r <= nxt_mask;
        ch_r <= low_bit(nxt_mask);
        smp_cnt_r <= samp_r[low_bit(nxt_mask)];
        rep_r <= 5'h00;
        acc_r <= REG_RST;
        src_r <= ctrl_r[CTRL_TRIGGER_CLASS_SELECT];
        state_r <= S_SAMPLE;
      end else begin
        case (state_r)
          S_SAMPLE: begin
            if (conv_clk_en_o) begin
              if (smp_cnt_r == 8'h00) begin
                state_r <= S_CONV;
              end else begin
                smp_cnt_r <= smp_cnt_r - 8'h01;
              end
            end
          end
          S_CONV: begin
            if (conv_done_i && rep_r != add_last) begin
              acc_r <= sum;
              rep_r <= rep_r + 5'h01;
              smp_cnt_r <= samp_r[ch_r];
              state_r <= S_SAMPLE;
            end else if (conv_done_i) begin
              acc_r <= REG_RST;
              rep_r <= 5'h00;
              if (|rem_left) begin
                rem_r <= rem_left;
                ch_r <= low_bit(rem_left);
                smp_cnt_r <= samp_r[low_bit(rem_left)];
                state_r <= S_SAMPLE;
              end else begin
                half_r[act_r] <= dbl_mode ? !half_r[act_r] : 1'b0;
                end_a_r <= end_fire && (act_r == 2'h0) && ctrl_r[CTRL_IRQ_EN];
                end_b_r <= end_fire && (act_r == 2'h1) && ext_r[EXT_GB_IRQ];
                end_c_r <= end_fire && (act_r == 2'h2) && ext_r[EXT_GC_IRQ];
                evt_r <= end_fire && !(|pend_all) && (mode != MODE_CONT);
                if (mode == MODE_CONT) begin
                  rem_r <= gmask[0];
                  ch_r <= low_bit(gmask[0]);
                  smp_cnt_r <= samp_r[low_bit(gmask[0])];
                  state_r <= S_SAMPLE;
                end else begin
                  state_r <= S_IDLE;
                end
              end
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

  assign scan_end_request_o = end_a_r;
  assign group_b_end_request_o = end_b_r;
  assign group_c_end_request_o = end_c_r;
  assign event_link_o = evt_r;

  ////////////////////////////////////////////////////////////////////////
  // results and duplicates; a store beats a same-cycle auto-clear
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 16; i++) begin
        result_r[i] <= REG_RST;
      end
      dup_r <= REG_RST;
      dup_t_r[0] <= REG_RST;
      dup_t_r[1] <= REG_RST;
    end else if (ce_i) begin
      if (reg_rd_i && acc_cfg_r[ACC_AUTOCLR] && reg_addr_i[5:4] == OFS_RESULT[5:4]) begin
        result_r[reg_addr_i[3:0]] <= REG_RST;
      end
      if (st_v) begin
        case (st_dst)
          2'h1: dup_r <= st_val;
          2'h2: dup_t_r[0] <= st_val;
          2'h3: dup_t_r[1] <= st_val;
          default: result_r[ch_r] <= st_val;
        endcase
      end
    end
  end

  for (genvar w = 0; w < 2; w++) begin : g_win
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        cmp_p_r[w] <= 1'b0;
      end else if (ce_i) begin
        cmp_p_r[w] <= st_v && (st_dst == 2'h0) && cmp_ctrl_r[2*w] && win_sel_r[w][ch_r] &&
                      (((st_val >= win_lo_r[w]) && (st_val <= win_hi_r[w])) != cmp_ctrl_r[2*w+1]);
      end
    end
  end

  assign window_a_compare_request_o = cmp_p_r[0];
  assign window_b_compare_request_o = cmp_p_r[1];

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ctrl_r <= REG_RST;
      ext_r <= REG_RST;
      acc_cfg_r <= REG_RST;
      add_sel_r <= REG_RST;
      trg_sel_r <= TRG_SEL_RST;
      cmp_ctrl_r <= REG_RST;
      for (int i = 0; i < 3; i++) begin
        sel_r[i] <= REG_RST;
      end
      for (int i = 0; i < 2; i++) begin
        win_lo_r[i] <= REG_RST;
        win_hi_r[i] <= REG_RST;
        win_sel_r[i] <= REG_RST;
      end
      for (int i = 0; i < 16; i++) begin
        samp_r[i] <= SAMP_RST;
      end
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == OFS_CTRL) begin
        ctrl_r <= reg_wdata_i & 16'h7FFF;
      end else if (reg_addr_i == OFS_EXT) begin
        ext_r <= reg_wdata_i;
      end else if (reg_addr_i == OFS_ACC) begin
        acc_cfg_r <= reg_wdata_i;
      end else if (reg_addr_i == OFS_SEL_A) begin
        sel_r[0] <= reg_wdata_i;
      end else if (reg_addr_i == OFS_SEL_B) begin
        sel_r[1] <= reg_wdata_i;
      end else if (reg_addr_i == OFS_SEL_C) begin
        sel_r[2] <= reg_wdata_i;
      end else if (reg_addr_i == OFS_ADD_SEL) begin
        add_sel_r <= reg_wdata_i;
      end else if (reg_addr_i == OFS_TRG_SEL) begin
        trg_sel_r <= reg_wdata_i;
      end else if (reg_addr_i == OFS_WIN_A_LO) begin
        win_lo_r[0] <= reg_wdata_i;
      end else if (reg_addr_i == OFS_WIN_A_HI) begin
        win_hi_r[0] <= reg_wdata_i;
      end else if (reg_addr_i == OFS_WIN_B_LO) begin
        win_lo_r[1] <= reg_wdata_i;
      end else if (reg_addr_i == OFS_WIN_B_HI) begin
        win_hi_r[1] <= reg_wdata_i;
      end else if (reg_addr_i == OFS_CMP_CTL) begin
        cmp_ctrl_r <= reg_wdata_i;
      end else if (reg_addr_i == OFS_WIN_A_SEL) begin
        win_sel_r[0] <= reg_wdata_i;
      end else if (reg_addr_i == OFS_WIN_B_SEL) begin
        win_sel_r[1] <= reg_wdata_i;
      end else if (reg_addr_i[5:4] == OFS_SAMP[5:4]) begin
        samp_r[reg_addr_i[3:0]] <= reg_wdata_i[7:0];
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rdata_r <= REG_RST;
    end else if (ce_i) begin
      rdata_r <= REG_RST;
      if (reg_rd_i) begin
        if (reg_addr_i == OFS_CTRL) begin
          rdata_r <= {busy_o, ctrl_r[14:0]};
        end else if (reg_addr_i == OFS_EXT) begin
          rdata_r <= ext_r;
        end else if (reg_addr_i == OFS_ACC) begin
          rdata_r <= acc_cfg_r;
        end else if (reg_addr_i == OFS_SEL_A) begin
          rdata_r <= sel_r[0];
        end else if (reg_addr_i == OFS_SEL_B) begin
          rdata_r <= sel_r[1];
        end else if (reg_addr_i == OFS_SEL_C) begin
          rdata_r <= sel_r[2];
        end else if (reg_addr_i == OFS_ADD_SEL) begin
          rdata_r <= add_sel_r;
        end else if (reg_addr_i == OFS_TRG_SEL) begin
          rdata_r <= trg_sel_r;
        end else if (reg_addr_i == OFS_WIN_A_LO) begin
          rdata_r <= win_lo_r[0];
        end else if (reg_addr_i == OFS_WIN_A_HI) begin
          rdata_r <= win_hi_r[0];
        end else if (reg_addr_i == OFS_WIN_B_LO) begin
          rdata_r <= win_lo_r[1];
        end else if (reg_addr_i == OFS_WIN_B_HI) begin
          rdata_r <= win_hi_r[1];
        end else if (reg_addr_i == OFS_CMP_CTL) begin
          rdata_r <= cmp_ctrl_r;
        end else if (reg_addr_i == OFS_WIN_A_SEL) begin
          rdata_r <= win_sel_r[0];
        end else if (reg_addr_i == OFS_WIN_B_SEL) begin
          rdata_r <= win_sel_r[1];
        end else if (reg_addr_i == OFS_STATUS) begin
          rdata_r <= {6'h00, src_r, half_r, pend_r, act_r, busy_o};
        end else if (reg_addr_i[5:4] == OFS_SAMP[5:4]) begin
          rdata_r <= {8'h00, samp_r[reg_addr_i[3:0]]};
        end else if (reg_addr_i[5:4] == OFS_RESULT[5:4]) begin
          rdata_r <= result_r[reg_addr_i[3:0]];
        end else if (reg_addr_i == OFS_DUP) begin
          rdata_r <= dup_r;
        end else if (reg_addr_i == OFS_DUP_SYNC) begin
          rdata_r <= dup_t_r[0];
        end else if (reg_addr_i == OFS_DUP_PIN) begin
          rdata_r <= dup_t_r[1];
        end
      end
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule

/* adcss_scan_sequencer_monitor.sv */
`timescale 1ns/1ps
module adcss_scan_sequencer_monitor
  import adcss_pkg::*;
#(
  parameter int NCH = 8,
  parameter int CLK_RATIO = 1
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic conv_clk_en_o,
  input wire logic conv_start_o,
  input wire logic [3:0] conv_ch_o,
  input wire logic [1:0] conv_res_o,
  input wire logic conv_done_i,
  input wire logic scan_end_request_o,
  input wire logic event_link_o,
  input wire logic busy_o
);
  logic irq_en_r;
  logic [15:0] sel_a_r;
  logic dbl_r;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////
  // config writes are only judged while idle, busy writes may be held off
  sequence s_go;
    ce_i && reg_wr_i && reg_addr_i == OFS_CTRL && reg_wdata_i[CTRL_START] && !busy_o &&
    !dbl_r && |sel_a_r[NCH-1:0];
  endsequence
  sequence s_res_wr;
    ce_i && reg_wr_i && reg_addr_i == OFS_EXT && !busy_o;
  endsequence
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      irq_en_r <= 1'b0;
      sel_a_r <= 16'h0000;
      dbl_r <= 1'b0;
    end else if (ce_i && reg_wr_i) begin
      // an empty selection never starts, so only judge starts with work to do
      if (reg_addr_i == OFS_CTRL) begin
        irq_en_r <= reg_wdata_i[CTRL_IRQ_EN];
      end else if (reg_addr_i == OFS_SEL_A) begin
        sel_a_r <= reg_wdata_i;
      end else if (reg_addr_i == OFS_EXT) begin
        dbl_r <= reg_wdata_i[EXT_DOUBLE_TRIGGER_ENABLE];
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  AST_GO_BUSY: assert property (s_go |=> busy_o)
    else $error("software start did not raise busy");
  AST_RES_CFG: assert property (s_res_wr |=> conv_res_o == $past(reg_wdata_i[EXT_RES_HI:EXT_RES_LO]))
    else $error("resolution code not applied");
  AST_START_PULSE: assert property (conv_start_o && ce_i |=> !conv_start_o)
    else $error("conversion start longer than one cycle");
  AST_START_BUSY: assert property (conv_start_o |-> busy_o)
    else $error("conversion started while idle");
  AST_CH_RANGE: assert property (conv_start_o |-> conv_ch_o < NCH)
    else $error("channel outside unit");
  AST_DONE_GAP: assert property (conv_done_i |-> !conv_start_o)
    else $error("next channel started before result stored");
  AST_END_GATE: assert property (scan_end_request_o |-> irq_en_r)
    else $error("scan end request while disabled");
  AST_END_BUSY: assert property (scan_end_request_o || event_link_o |-> $past(busy_o))
    else $error("end pulse without a scan");
  AST_RD_IDLE: assert property ($past(ce_i) && !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read slot");
  AST_CLK_EN: assert property (CLK_RATIO == 1 && ce_i |-> conv_clk_en_o)
    else $error("conversion clock enable dropped at ratio one");
endmodule

bind adcss_scan_sequencer adcss_scan_sequencer_monitor #(.NCH(NCH), .CLK_RATIO(CLK_RATIO)) i_adcss_scan_sequencer_monitor (
  .core_clk_i, .rstn_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .conv_clk_en_o, .conv_start_o, .conv_ch_o, .conv_res_o, .conv_done_i, .scan_end_request_o,
  .event_link_o, .busy_o);

/* adcss_conv_model.sv */
`timescale 1ns/1ps
module adcss_conv_model (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic conv_start_i,
  input wire logic [3:0] conv_ch_i,
  input wire logic [3:0] dly_i,
  output logic conv_done_o,
  output logic [11:0] conv_data_o
);
  logic busy_r;
  logic [3:0] cnt_r;
  logic [3:0] ch_r;
  // data toggles outside the done cycle so a late sample never matches
  always_ff @(posedge core_clk_i) begin
    conv_done_o <= 1'b0;
    conv_data_o <= ~conv_data_o;
    if (!rstn_i) begin
      busy_r <= 1'b0;
      conv_data_o <= 12'h555;
    end else if (conv_start_i) begin
      busy_r <= 1'b1;
      cnt_r <= dly_i;
      ch_r <= conv_ch_i;
    end else if (busy_r && cnt_r == 4'h0) begin
      busy_r <= 1'b0;
      conv_done_o <= 1'b1;
      conv_data_o <= {ch_r, 8'h3C};
    end else begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule

/* tb_adc_scan_sequencer.sv */
`timescale 1ns/1ps
module tb_adc_scan_sequencer import adcss_pkg::*;;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, pin_n = 1, cs, done, se, gbe, gce, wa, wb, ev, busy;
  logic [5:0] addr = 6'h00;
  logic [15:0] wd = 16'h0000, trig = 16'h0000, rdata;
  logic [3:0] ch, dly = 4'h5;
  logic [1:0] res;
  logic [11:0] cd;
  int n_mismatch = 0, num_checks = 0, n_start = 0, n_end = 0, n_gb = 0, s0, e0;
  int n_gc = 0, n_ev = 0, n_wa = 0, n_wb = 0;
  adcss_scan_sequencer i_adcss_scan_sequencer (.core_clk_i(clk), .rstn_i(rstn), .ce_i(1'b1),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .sync_trig_i(trig), .ext_trigger_pin_n_i(pin_n), .conv_clk_en_o(), .conv_start_o(cs),
    .conv_ch_o(ch), .conv_res_o(res), .conv_done_i(done), .conv_data_i(cd), .scan_end_request_o(se),
    .group_b_end_request_o(gbe), .group_c_end_request_o(gce), .window_a_compare_request_o(wa),
    .window_b_compare_request_o(wb), .event_link_o(ev), .busy_o(busy));
  adcss_conv_model i_adcss_conv_model (.core_clk_i(clk), .rstn_i(rstn), .conv_start_i(cs),
    .conv_ch_i(ch), .dly_i(dly), .conv_done_o(done), .conv_data_o(cd));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    n_start <= n_start + int'(cs);
    n_end <= n_end + int'(se);
    n_gb <= n_gb + int'(gbe);
    n_gc <= n_gc + int'(gce);
    n_ev <= n_ev + int'(ev);
    n_wa <= n_wa + int'(wa);
    n_wb <= n_wb + int'(wb);
  end
  ////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // a gap cycle after each strobe keeps one assignment per time step
  task wr_reg(input logic [5:0] a, input logic [15:0] d);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd_reg(input logic [5:0] a, input logic [15:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge clk);
  endtask
  task pulse(input logic [15:0] t);
    trig <= t;
    @(posedge clk);
    trig <= 16'h0000;
  endtask
  task fin(input int es, input int ee);
    int i;
    i = 0;
    // let a start taken at the calling edge show on busy first
    @(negedge clk);
    while (busy !== 1'b0 && i < 3000) begin
      @(negedge clk);
      i++;
    end
    if (i == 3000) begin
      n_mismatch++;
      end_of_test;
    end
    // the end pulse is counted one edge after busy drops
    repeat (2) @(posedge clk);
    chk(16'(n_start - s0), 16'(es));
    chk(16'(n_end - e0), 16'(ee));
    s0 = n_start;
    e0 = n_end;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd_reg(OFS_TRG_SEL, TRG_SEL_RST);
    rd_reg(OFS_SAMP, {8'h00, SAMP_RST});
    rd_reg(OFS_CTRL, REG_RST);
    rd_reg(6'h3F, 16'h0000);
    $display("test reset done");
    wr_reg(OFS_SEL_A, 16'h0005);
    fin(0, 0);
    wr_reg(OFS_CTRL, 16'h9000);
    fin(2, 1);
    rd_reg(OFS_RESULT, 16'h003C);
    rd_reg(OFS_RESULT + 6'h02, 16'h023C);
    rd_reg(OFS_RESULT + 6'h01, 16'h0000);
    $display("test single done");
    dly <= 4'h0;
    wr_reg(OFS_EXT, 16'h1000);
    wr_reg(OFS_ACC, 16'h0011);
    wr_reg(OFS_ADD_SEL, 16'h0004);
    wr_reg(OFS_CTRL, 16'h8000);
    fin(3, 0);
    rd_reg(OFS_RESULT + 6'h02, 16'h0046);
    rd_reg(OFS_RESULT + 6'h02, 16'h0000);
    $display("test add done");
    wr_reg(OFS_ACC, 16'h0000);
    wr_reg(OFS_EXT, 16'h0000);
    wr_reg(OFS_SEL_A, 16'h0001);
    wr_reg(OFS_CTRL, 16'hC000);
    repeat (200) @(posedge clk);
    wr_reg(OFS_CTRL, 16'h0000);
    chk(16'(n_start - s0 > 10), 16'h0001);
    s0 = n_start;
    fin(0, 0);
    $display("test continuous done");
    wr_reg(OFS_TRG_SEL, 16'hFFF3);
    wr_reg(OFS_CTRL, 16'h1000);
    pulse(16'h0008);
    repeat (50) @(posedge clk);
    fin(0, 0);
    wr_reg(OFS_CTRL, 16'h1200);
    pulse(16'h0008);
    fin(1, 1);
    wr_reg(OFS_CTRL, 16'h1300);
    pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    fin(1, 1);
    pin_n <= 1'b1;
    $display("test trigger done");
    wr_reg(OFS_TRG_SEL, 16'hF210);
    wr_reg(OFS_SEL_B, 16'h0004);
    wr_reg(OFS_SEL_C, 16'h0002);
    wr_reg(OFS_EXT, 16'h00C0);
    wr_reg(OFS_CTRL, 16'h3200);
    pulse(16'h0002);
    fin(1, 0);
    chk(16'(n_gb), 16'h0001);
    pulse(16'h0004);
    fin(1, 0);
    chk(16'(n_gc), 16'h0001);
    $display("test group done");
    // mode is set apart from the start so the scan uses the new mode
    wr_reg(OFS_EXT, 16'h0022);
    wr_reg(OFS_CTRL, 16'h1000);
    wr_reg(OFS_CTRL, 16'h9000);
    fin(1, 0);
    wr_reg(OFS_CTRL, 16'h9000);
    fin(1, 1);
    rd_reg(OFS_DUP, 16'h023C);
    $display("test double done");
    wr_reg(OFS_EXT, 16'h0000);
    wr_reg(OFS_SEL_A, 16'h0005);
    wr_reg(OFS_WIN_A_LO, 16'h0030);
    wr_reg(OFS_WIN_A_HI, 16'h0040);
    wr_reg(OFS_WIN_A_SEL, 16'h0001);
    wr_reg(OFS_WIN_B_HI, 16'h0100);
    wr_reg(OFS_WIN_B_SEL, 16'h0004);
    wr_reg(OFS_CMP_CTL, 16'h000D);
    wr_reg(OFS_CTRL, 16'h8000);
    fin(2, 0);
    chk(16'(n_wa), 16'h0001);
    chk(16'(n_wb), 16'h0001);
    chk(16'(n_ev), 16'h0008);
    $display("test compare done");
    end_of_test;
  end
endmodule
